// *** hw/rcd_cmd_decoder.sv ***
// nibble command decoder for record and playback conditions
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "rcd_cfg.svh"
module rcd_cmd_decoder
  import rcd_pkg::*;
#(
  parameter logic [`RCD_BUSY_W-1:0] BUSY_LONG_CYC =
    `RCD_BUSY_W'(`RCD_T_LONG_US * `RCD_CLK_MHZ)
) (
  input  wire logic        sys_clk,     // master clock
  input  wire logic        resetn,      // sync reset, low
  input  wire logic [7:0]  awaddr,      // axi write addr
  input  wire logic        awvalid,     // axi
  output logic             awready,     // axi
  input  wire logic [31:0] wdata,       // axi
  input  wire logic [3:0]  wstrb,       // axi
  input  wire logic        wvalid,      // axi
  output logic             wready,      // axi
  output logic [1:0]       bresp,       // axi
  output logic             bvalid,      // axi
  input  wire logic        bready,      // axi
  input  wire logic [7:0]  araddr,      // axi read addr
  input  wire logic        arvalid,     // axi
  output logic             arready,     // axi
  output logic [31:0]      rdata,       // axi
  output logic [1:0]       rresp,       // axi
  output logic             rvalid,      // axi
  input  wire logic        rready,      // axi
  input  wire logic [3:0]  nib_in,      // data pins in
  output logic [3:0]       nib_out,     // data pins out
  output logic             nib_oe,      // data pins drive
  input  wire logic        wr_n,        // write strobe, low
  input  wire logic        rd_n,        // read strobe, low
  input  wire logic        ce_n,        // chip enable, low
  input  wire logic        ce,          // chip enable, high
  input  wire logic        voice_in,    // level over threshold
  output logic             busy,        // busy pin
  output logic [1:0]       thresh_code, // threshold select
  output logic [2:0]       sample_bits, // bits per sample
  output logic             sample_tick, // sampling strobe
  output logic             store_en,    // store samples
  output logic             erase_pulse, // erase phrase
  output logic             copy_pulse,  // copy index entry
  output logic             voice_wait,  // waiting for voice
  output logic             op_active    // operation running
);
  rcd_pins_t   sy1_reg, sy2_reg, sy3_reg, pins;
  rcd_cmd_st_t cst_reg;
  rcd_op_st_t  op_reg, op_next;
  rcd_cond_t   cond_reg;
  logic [3:0]  opc_reg, idx_reg, nib, stat_nib;
  logic [7:0]  param_reg, phrase_reg, blocks_reg, unused_reg;
  logic [7:0]  pval, blk_val, aw_q, ar_q;
  logic [15:0] cap_reg;
  logic [39:0] entry_reg;
  logic [10:0] div_reg;
  logic [2:0]  bits_reg;
  logic [1:0]  need_reg;
  logic [31:0] w_q, rd_word;
  logic [3:0]  ws_q;
  logic [`RCD_BUSY_W-1:0] bcnt_reg, bload;
  logic        busy_reg, bad_reg, rec_reg, tick_reg, store_reg;
  logic        erase_reg, copy_reg, vw_reg, act_reg, oe_reg;
  logic        awr_reg, wr_reg, bv_reg, arr_reg, rv_reg, rd_err;
  logic [1:0]  br_reg, rr_reg;
  logic [3:0]  dout_reg;
  logic [31:0] rdat_reg;
  logic        en, wr_fall, rd_fall, free, wr_ok, rd_ok;
  logic        cmd_take, start_cmd, stop_cmd, param_done;
  logic        long_cmd, awr_nib, ard_nib, brd_nib, do_wr;
  logic        erase_n, copy_n, bset, wr_err, dummy;

  function automatic logic [10:0] rate_div(input logic [1:0] r);
    case (r)
      2'h0:    rate_div = `RCD_DIV_R0;
      2'h1:    rate_div = `RCD_DIV_R1;
      2'h2:    rate_div = `RCD_DIV_R2;
      default: rate_div = `RCD_DIV_R3;
    endcase
  endfunction

  function automatic logic phrase_ok(input logic [1:0] m,
                                     input logic [7:0] p);
    case (m)
      2'h1:    phrase_ok = (p != 8'h00);
      default: phrase_ok = (p <= `RCD_PH_LAST);
    endcase
  endfunction

  assign pins = '{wr_n, rd_n, ce_n, ce, voice_in, nib_in};

  // pin synchroniser, third stage only for edges
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sy1_reg <= `RCD_PINS_IDLE;
      sy2_reg <= `RCD_PINS_IDLE;
      sy3_reg <= `RCD_PINS_IDLE;
    end else begin
      sy1_reg <= pins;
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
    end
  end

  assign nib     = sy2_reg.data;
  assign en      = !sy2_reg.ce_n && sy2_reg.ce;
  assign wr_fall = en && sy3_reg.wr_n && !sy2_reg.wr_n;
  assign rd_fall = en && sy3_reg.rd_n && !sy2_reg.rd_n;
  assign free    = (bcnt_reg == '0);
  assign wr_ok   = wr_fall && free;
  assign rd_ok   = rd_fall && free;
  assign cmd_take  = wr_ok && (cst_reg == CS_IDLE);
  assign start_cmd = cmd_take && (nib == `RCD_OP_START);
  assign stop_cmd  = cmd_take && (nib == `RCD_OP_STOP);
  assign long_cmd  = cmd_take && ((nib == `RCD_OP_BLOCK_COUNT_READ_COMMAND) ||
                     (nib[3:1] == `RCD_OP_ADR3));
  assign param_done = wr_ok && (cst_reg == CS_PARAM) &&
                      (need_reg == 2'h1);
  assign awr_nib = wr_ok && (cst_reg == CS_AWR);
  assign ard_nib = rd_ok && (cst_reg == CS_ARD);
  assign brd_nib = rd_ok && (cst_reg == CS_BRD);
  assign pval = ((opc_reg == `RCD_OP_RATE) ||
                 (opc_reg == `RCD_OP_VDS)) ? {4'h0, nib} :
                {nib, param_reg[7:4]};
  assign blk_val = (phrase_reg == 8'h00) ? unused_reg : blocks_reg;
  assign stat_nib = {bad_reg, vw_reg, act_reg, busy_reg};
  assign dummy = (cond_reg.mode == `RCD_MODE_DROM) &&
                 ((idx_reg == `RCD_ADR_DUM0) ||
                  (idx_reg == `RCD_ADR_DUM1));

  // busy reload on every accepted write nibble and on every data read nibble, not on status reads
  always_comb begin
    bset  = wr_ok || ard_nib || brd_nib;
    bload = `RCD_BUSY_W'(`RCD_T_SHORT_US * `RCD_CLK_MHZ);
    if (long_cmd)
      bload = BUSY_LONG_CYC;
    else if (awr_nib || ard_nib || brd_nib)
      bload = `RCD_BUSY_W'(`RCD_T_DATA_US * `RCD_CLK_MHZ);
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bcnt_reg <= '0;
      busy_reg <= 1'b0;
    end else if (bset) begin
      bcnt_reg <= bload;
      busy_reg <= 1'b1;
    end else begin
      bcnt_reg <= free ? bcnt_reg : bcnt_reg - 1'b1;
      busy_reg <= (bcnt_reg > `RCD_BUSY_W'(1));
    end
  end

  // command sequencer
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cst_reg   <= CS_IDLE;
      opc_reg   <= `RCD_OP_NOP;
      need_reg  <= 2'h0;
      param_reg <= 8'h00;
      idx_reg   <= 4'h0;
    end else begin
      case (cst_reg)
        CS_IDLE: if (wr_ok) begin
          opc_reg <= nib;
          idx_reg <= 4'h0;
          if (nib == `RCD_OP_RATE || nib == `RCD_OP_VDS) begin
            cst_reg  <= CS_PARAM;
            need_reg <= 2'h1;
          end else if (nib == `RCD_OP_PHRASE ||
                       nib == `RCD_OP_BLOCK_COUNT_WRITE_COMMAND) begin
            cst_reg  <= CS_PARAM;
            need_reg <= 2'h2;
          end else if (nib == `RCD_OP_BLOCK_COUNT_READ_COMMAND) begin
            cst_reg <= CS_BRD;
          end else if (nib[3:1] == `RCD_OP_ADR3) begin
            cst_reg <= nib[0] ? CS_ARD : CS_AWR;
          end
        end
        CS_PARAM: if (wr_ok) begin
          param_reg <= {nib, param_reg[7:4]};
          need_reg  <= need_reg - 2'h1;
          if (need_reg == 2'h1)
            cst_reg <= CS_IDLE;
        end
        CS_AWR: if (wr_ok) begin
          idx_reg <= idx_reg + 4'h1;
          if (idx_reg == `RCD_ADR_LAST)
            cst_reg <= CS_IDLE;
        end
        CS_ARD: if (rd_ok) begin
          idx_reg <= idx_reg + 4'h1;
          if (idx_reg == `RCD_ADR_LAST)
            cst_reg <= CS_IDLE;
        end
        CS_BRD: if (rd_ok) begin
          idx_reg <= idx_reg + 4'h1;
          if (idx_reg[0])
            cst_reg <= CS_IDLE;
        end
        default: cst_reg <= CS_IDLE;
      endcase
    end
  end

  // conditions set by parameter commands, record/play mode by the REC and PLAY commands
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cond_reg   <= '0;
      phrase_reg <= 8'h00;
      blocks_reg <= 8'h00;
      rec_reg    <= 1'b0;
      bits_reg   <= `RCD_BITS3;
    end else begin
      if (cmd_take && nib == `RCD_OP_REC)
        rec_reg <= 1'b1;
      if (cmd_take && nib == `RCD_OP_PLAY)
        rec_reg <= 1'b0;
      if (param_done) begin
        case (opc_reg)
          `RCD_OP_RATE: begin
            cond_reg.mode <= pval[`RCD_F_MODE];
            cond_reg.rate <= pval[`RCD_F_RATE];
          end
          `RCD_OP_VDS: begin
            cond_reg.bitlen <= pval[`RCD_F_BITLEN];
            bits_reg <= pval[`RCD_F_BITLEN] ? `RCD_BITS4 : `RCD_BITS3;
            cond_reg.thresh <= pval[`RCD_F_THR];
          end
          `RCD_OP_PHRASE: phrase_reg <= pval;
          `RCD_OP_BLOCK_COUNT_WRITE_COMMAND:
            if (!cond_reg.mode[1] && pval != 8'h00)
              blocks_reg <= pval;
          default: ;
        endcase
      end
    end
  end

  // illegal phrase flag, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (!resetn)
      bad_reg <= 1'b0;
    else if (param_done && opc_reg == `RCD_OP_PHRASE &&
             !phrase_ok(cond_reg.mode, pval))
      bad_reg <= 1'b1;
    else if (do_wr && aw_q == `RCD_A_STATUS && ws_q[0] &&
             w_q[`RCD_ST_BAD])
      bad_reg <= 1'b0;
  end

  // index entry written nibble by nibble, low first
  always_ff @(posedge sys_clk) begin
    if (!resetn)
      entry_reg <= '0;
    else if (awr_nib)
      entry_reg[{idx_reg, 2'b00} +: 4] <= dummy ? 4'h0 : nib;
  end

  // operation state and status flags
  always_comb begin
    op_next = op_reg;
    erase_n = 1'b0;
    copy_n  = 1'b0;
    case (op_reg)
      OP_IDLE: if (start_cmd && !(cond_reg.mode == `RCD_MODE_FLEX &&
                   phrase_reg == 8'h00)) begin
        if (rec_reg)
          op_next = (cond_reg.thresh != 2'h0) ? OP_WAIT : OP_RUN;
        else begin
          op_next = OP_RUN;
          copy_n  = (cond_reg.mode == `RCD_MODE_DROM);
        end
      end
      OP_WAIT: if (stop_cmd) begin
        op_next = OP_IDLE;
        erase_n = (cond_reg.mode == `RCD_MODE_FLEX);
      end else if (sy2_reg.voice) begin
        op_next = OP_RUN;
      end
      OP_RUN: if (stop_cmd)
        op_next = OP_IDLE;
      default: op_next = OP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      op_reg    <= OP_IDLE;
      vw_reg    <= 1'b0;
      act_reg   <= 1'b0;
      store_reg <= 1'b0;
      erase_reg <= 1'b0;
      copy_reg  <= 1'b0;
    end else begin
      op_reg    <= op_next;
      vw_reg    <= (op_next == OP_WAIT);
      act_reg   <= (op_next != OP_IDLE);
      store_reg <= (op_next == OP_RUN) && rec_reg;
      erase_reg <= erase_n;
      copy_reg  <= copy_n;
    end
  end

  // sampling divider
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg >= rate_div(cond_reg.rate) - 11'h1) begin
      div_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 11'h1;
      tick_reg <= 1'b0;
    end
  end

  // read nibbles: status, or data while a read command runs
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dout_reg <= 4'h0;
      oe_reg   <= 1'b0;
    end else begin
      oe_reg <= en && !sy2_reg.rd_n;
      if (rd_fall) begin
        if (cst_reg == CS_BRD)
          dout_reg <= !free ? 4'h0 :
                      (idx_reg[0] ? blk_val[7:4] : blk_val[3:0]);
        else if (cst_reg == CS_ARD)
          dout_reg <= free ? entry_reg[{idx_reg, 2'b00} +: 4] : 4'h0;
        else
          dout_reg <= stat_nib;
      end
    end
  end

  // axi4-lite slave
  assign do_wr  = !awr_reg && !wr_reg && !bv_reg;
  assign wr_err = !(aw_q == `RCD_A_UNUSED || aw_q == `RCD_A_CAP ||
                    aw_q == `RCD_A_STATUS);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      awr_reg <= 1'b1;
      wr_reg  <= 1'b1;
      bv_reg  <= 1'b0;
      br_reg  <= `RCD_RESP_OK;
      aw_q    <= 8'h00;
      w_q     <= '0;
      ws_q    <= 4'h0;
    end else begin
      if (awvalid && awr_reg) begin
        awr_reg <= 1'b0;
        aw_q    <= awaddr;
      end
      if (wvalid && wr_reg) begin
        wr_reg <= 1'b0;
        w_q    <= wdata;
        ws_q   <= wstrb;
      end
      if (do_wr) begin
        bv_reg <= 1'b1;
        br_reg <= wr_err ? `RCD_RESP_ERR : `RCD_RESP_OK;
      end
      if (bv_reg && bready) begin
        bv_reg  <= 1'b0;
        awr_reg <= 1'b1;
        wr_reg  <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      unused_reg <= 8'h00;
      cap_reg    <= `RCD_CAP_RESET;
    end else if (do_wr) begin
      if (aw_q == `RCD_A_UNUSED && ws_q[0])
        unused_reg <= w_q[7:0];
      if (aw_q == `RCD_A_CAP) begin
        if (ws_q[0])
          cap_reg[7:0] <= w_q[7:0];
        if (ws_q[1])
          cap_reg[15:8] <= w_q[15:8];
      end
    end
  end

  always_comb begin
    rd_word = '0;
    rd_err  = 1'b0;
    case (ar_q)
      `RCD_A_CONFIG: rd_word = {25'h0, cond_reg};
      `RCD_A_PHRASE: rd_word = {24'h0, phrase_reg};
      `RCD_A_BLOCKS: rd_word = {24'h0, blocks_reg};
      `RCD_A_STATUS: rd_word = {28'h0, stat_nib};
      `RCD_A_ENT_LO: rd_word = entry_reg[31:0];
      `RCD_A_ENT_HI: rd_word = {24'h0, entry_reg[39:32]};
      `RCD_A_UNUSED: rd_word = {24'h0, unused_reg};
      `RCD_A_CAP:    rd_word = {16'h0, cap_reg};
      `RCD_A_BLKSZ:  rd_word = {24'h0, cap_reg[15:8]};
      default:       rd_err  = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      arr_reg  <= 1'b1;
      rv_reg   <= 1'b0;
      ar_q     <= 8'h00;
      rdat_reg <= '0;
      rr_reg   <= `RCD_RESP_OK;
    end else begin
      if (arvalid && arr_reg) begin
        arr_reg <= 1'b0;
        ar_q    <= araddr;
      end
      if (!arr_reg && !rv_reg) begin
        rv_reg   <= 1'b1;
        rdat_reg <= rd_word;
        rr_reg   <= rd_err ? `RCD_RESP_ERR : `RCD_RESP_OK;
      end
      if (rv_reg && rready) begin
        rv_reg  <= 1'b0;
        arr_reg <= 1'b1;
      end
    end
  end

  assign awready = awr_reg;
  assign wready  = wr_reg;
  assign bvalid  = bv_reg;
  assign bresp   = br_reg;
  assign arready = arr_reg;
  assign rvalid  = rv_reg;
  assign rdata   = rdat_reg;
  assign rresp   = rr_reg;
  assign nib_out = dout_reg;
  assign nib_oe  = oe_reg;
  assign busy    = busy_reg;
  assign thresh_code = cond_reg.thresh;
  assign sample_bits = bits_reg;
  assign sample_tick = tick_reg;
  assign store_en    = store_reg;
  assign erase_pulse = erase_reg;
  assign copy_pulse  = copy_reg;
  assign voice_wait  = vw_reg;
  assign op_active   = act_reg;

  sequence s_wait_stop;
    (op_reg == OP_WAIT) && stop_cmd;
  endsequence
  sequence s_flags_clear;
    !vw_reg && !act_reg;
  endsequence

  property p_wait_flags;
    @(posedge sys_clk) disable iff (!resetn)
    (op_next == OP_WAIT) |=> vw_reg && act_reg && !store_reg;
  endproperty
  a_wait_flags: assert property (p_wait_flags)
    else $error("wait flags wrong");

  property p_stop_wait;
    @(posedge sys_clk) disable iff (!resetn)
    s_wait_stop |=> s_flags_clear;
  endproperty
  a_stop_wait: assert property (p_stop_wait)
    else $error("stop in wait left flags set");

  property p_erase;
    @(posedge sys_clk) disable iff (!resetn)
    s_wait_stop |=> (erase_reg ==
                     ($past(cond_reg.mode) == `RCD_MODE_FLEX));
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase pulse wrong");

  property p_voice_go;
    @(posedge sys_clk) disable iff (!resetn)
    (op_reg == OP_WAIT) && sy2_reg.voice && !stop_cmd
      |=> !vw_reg && store_reg;
  endproperty
  a_voice_go: assert property (p_voice_go)
    else $error("recording did not begin");

  property p_blk_zero;
    @(posedge sys_clk) disable iff (!resetn)
    param_done && opc_reg == `RCD_OP_BLOCK_COUNT_WRITE_COMMAND &&
      (pval == 8'h00 || cond_reg.mode[1]) |=> $stable(blocks_reg);
  endproperty
  a_blk_zero: assert property (p_blk_zero)
    else $error("refused block count stored");

  property p_busy_param;
    @(posedge sys_clk) disable iff (!resetn)
    param_done |=> busy_reg [*8];
  endproperty
  a_busy_param: assert property (p_busy_param)
    else $error("busy missing after nibble");

  property p_brd_busy;
    @(posedge sys_clk) disable iff (!resetn)
    long_cmd |=> (bcnt_reg == BUSY_LONG_CYC) ##1 busy_reg;
  endproperty
  a_brd_busy: assert property (p_brd_busy)
    else $error("long busy not loaded");

  property p_tick;
    @(posedge sys_clk) disable iff (!resetn)
    tick_reg |=> !tick_reg [*8];
  endproperty
  a_tick: assert property (p_tick)
    else $error("sample tick too close");

  property p_dummy;
    @(posedge sys_clk) disable iff (!resetn)
    awr_nib && dummy |=> (entry_reg[{$past(idx_reg), 2'b00} +: 4]
                          == 4'h0);
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("dummy nibble stored");

  property p_zero_phrase;
    @(posedge sys_clk) disable iff (!resetn)
    start_cmd && op_reg == OP_IDLE && phrase_reg == 8'h00 &&
      cond_reg.mode == `RCD_MODE_FLEX |=> !act_reg;
  endproperty
  a_zero_phrase: assert property (p_zero_phrase)
    else $error("flex phrase zero started");
endmodule

// *** inc/rcd_cfg.svh ***
// constants for the recorder condition command decoder
`ifndef RCD_CFG_SVH
`define RCD_CFG_SVH
`define RCD_CLK_MHZ    20
`define RCD_T_SHORT_US 16
`define RCD_T_LONG_US  270
`define RCD_T_DATA_US  50
`define RCD_BUSY_W     13
`define RCD_OP_NOP     4'h0
`define RCD_OP_START   4'h1
`define RCD_OP_STOP    4'h2
`define RCD_OP_REC     4'h3
`define RCD_OP_PLAY    4'h4
`define RCD_OP_RATE    4'h5
`define RCD_OP_VDS     4'h6
`define RCD_OP_PHRASE  4'h7
`define RCD_OP_BLOCK_COUNT_WRITE_COMMAND   4'hA
`define RCD_OP_BLOCK_COUNT_READ_COMMAND   4'hB
`define RCD_OP_ADR3    3'h4
`define RCD_F_MODE     1:0
`define RCD_F_RATE     3:2
`define RCD_F_BITLEN   0
`define RCD_F_THR      2:1
`define RCD_MODE_FLEX  2'h0
`define RCD_MODE_DROM  2'h3
`define RCD_DIV_R0     11'h400
`define RCD_DIV_R1     11'h300
`define RCD_DIV_R2     11'h280
`define RCD_DIV_R3     11'h200
`define RCD_BITS3      3'h3
`define RCD_BITS4      3'h4
`define RCD_PH_LAST    8'h3F
`define RCD_ADR_LAST   4'h9
`define RCD_ADR_DUM0   4'h5
`define RCD_ADR_DUM1   4'h9
`define RCD_PINS_IDLE  9'h1C0
`define RCD_A_CONFIG   8'h00
`define RCD_A_PHRASE   8'h04
`define RCD_A_BLOCKS   8'h08
`define RCD_A_STATUS   8'h0C
`define RCD_A_ENT_LO   8'h10
`define RCD_A_ENT_HI   8'h14
`define RCD_A_UNUSED   8'h18
`define RCD_A_CAP      8'h1C
`define RCD_A_BLKSZ    8'h20
`define RCD_CAP_RESET  16'h2000
`define RCD_ST_BAD     3
`define RCD_RESP_OK    2'h0
`define RCD_RESP_ERR   2'h2
`endif

// *** inc/rcd_pkg.sv ***
// types for the recorder condition command decoder
package rcd_pkg;
  typedef struct packed {
    logic [1:0] thresh;
    logic       bitlen;
    logic [1:0] rate;
    logic [1:0] mode;
  } rcd_cond_t;
  typedef struct packed {
    logic       wr_n;
    logic       rd_n;
    logic       ce_n;
    logic       ce;
    logic       voice;
    logic [3:0] data;
  } rcd_pins_t;
  typedef enum logic [2:0] {
    CS_IDLE  = 3'h0,
    CS_PARAM = 3'h1,
    CS_BRD   = 3'h3,
    CS_AWR   = 3'h2,
    CS_ARD   = 3'h6
  } rcd_cmd_st_t;
  typedef enum logic [1:0] {
    OP_IDLE = 2'h0,
    OP_WAIT = 2'h1,
    OP_RUN  = 2'h3
  } rcd_op_st_t;
endpackage

// *** sim/rcd_host.sv ***
// host microcontroller model on the nibble bus
`timescale 1ns/1ns
module rcd_host (
  input  wire logic       sys_clk, // clock
  input  wire logic       busy,    // device busy pin
  input  wire logic [3:0] nib_out, // device data
  output logic [3:0]      nib_in,  // host data
  output logic            wr_n,    // write strobe, low
  output logic            rd_n,    // read strobe, low
  output logic            ce_n,    // enable, low
  output logic            ce       // enable, high
);
  initial begin
    nib_in = 4'hA;
    wr_n = 1'b1;
    rd_n = 1'b1;
    ce_n = 1'b0;
    ce = 1'b1;
  end
  // status reads are unusable in reads, so watch the pin
  task automatic wait_free;
    repeat (6) @(posedge sys_clk);
    while (busy !== 1'b0) @(posedge sys_clk);
  endtask
  task automatic set_en(input logic lo_n, input logic hi);
    @(posedge sys_clk);
    ce_n <= lo_n;
    ce <= hi;
  endtask
  task automatic wr_nib(input logic [3:0] d);
    wait_free();
    nib_in <= d;
    wr_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    nib_in <= ~d;
  endtask
  task automatic rd_nib(output logic [3:0] q);
    wait_free();
    rd_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    q = nib_out;
    rd_n <= 1'b1;
  endtask
endmodule

// *** sim/tb.sv ***
// self-checking bench for the command decoder
`timescale 1ns/1ns
module tb;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready, voice_in;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  nib_in, nib_out, q0, q1, wstrb, nb;
  logic [39:0] ent;
  logic [3:0]  ent_q[$];
  logic        awready, wready, bvalid, arready, rvalid, nib_oe;
  logic        wr_n, rd_n, ce_n, ce, busy, tick, store_en, erase;
  logic        copy_pulse, voice_wait, op_active;
  logic [1:0]  bresp, rresp, rs, thr;
  logic [2:0]  bits;
  logic [7:0]  blk;
  int          bad_count = 0, n_checks = 0, cyc = 0, c, m, seen = 0, cps = 0;
  int          divs[4] = '{1024, 768, 640, 512};
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (erase === 1'b1) seen++;
    if (copy_pulse === 1'b1) cps++;
    if (cyc == 90000) begin
      bad_count++;
      give_verdict();
    end
  end
  rcd_host i_host (.sys_clk(sys_clk), .busy(busy), .nib_out(nib_out),
    .nib_in(nib_in), .wr_n(wr_n), .rd_n(rd_n), .ce_n(ce_n), .ce(ce));
  rcd_cmd_decoder #(.BUSY_LONG_CYC(13'h40)) i_dut (.sys_clk(sys_clk),
    .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .nib_in(nib_in), .nib_out(nib_out), .nib_oe(nib_oe), .wr_n(wr_n),
    .rd_n(rd_n), .ce_n(ce_n), .ce(ce), .voice_in(voice_in),
    .busy(busy), .thresh_code(thr), .sample_bits(bits),
    .sample_tick(tick), .store_en(store_en), .erase_pulse(erase),
    .copy_pulse(copy_pulse), .voice_wait(voice_wait),
    .op_active(op_active));
  task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge sys_clk);
    while (arready !== 1'b1) @(posedge sys_clk);
    arvalid <= 1'b0;
    @(posedge sys_clk);
    while (rvalid !== 1'b1) @(posedge sys_clk);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (awready === 1'b1) aw_ok = 1'b1;
      if (wready === 1'b1) w_ok = 1'b1;
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr2(input logic [3:0] a, input logic [3:0] b);
    i_host.wr_nib(a);
    i_host.wr_nib(b);
  endtask
  initial begin
    {awaddr, araddr, wdata, wstrb} <= '0;
    {awvalid, wvalid, bready, arvalid, rready, voice_in} <= '0;
    void'($urandom(32'h60a8));
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    axi_rd(8'h00);
    chk("config reset", rd, 32'h0);
    chk("oe idle", nib_oe, 1'b0);
    axi_rd(8'h3C);
    chk("unmapped resp", rs, 32'h2);
    for (m = 0; m < 4; m++) begin
      wr2(4'h5, 4'((3 - m) * 4 + m));
      axi_rd(8'h00);
      chk("mode rate", rd, 32'((3 - m) * 4 + m));
      @(posedge sys_clk);
      while (tick !== 1'b1) @(posedge sys_clk);
      c = 0;
      do begin
        @(posedge sys_clk);
        c++;
      end while (tick !== 1'b1 && c < 2000);
      chk("tick period", c, divs[3 - m]);
    end
    for (m = 0; m < 4; m++) begin
      wr2(4'h6, 4'(m * 2 + m % 2));
      repeat (2) @(posedge sys_clk);
      chk("sample bits", bits, (m % 2) ? 3'h4 : 3'h3);
      chk("thresh code", thr, m);
    end
    i_host.set_en(1'b0, 1'b0);
    wr2(4'h6, 4'h0);
    i_host.set_en(1'b1, 1'b1);
    wr2(4'h6, 4'h0);
    i_host.set_en(1'b0, 1'b1);
    repeat (4) @(posedge sys_clk);
    chk("disabled write", thr, 2'h3);
    wr2(4'h5, 4'h0);
    wr2(4'h6, 4'h2);
    wr2(4'h7, 4'h1);
    i_host.wr_nib(4'h0);
    i_host.wr_nib(4'h3);
    i_host.wr_nib(4'h1);
    i_host.wait_free();
    chk("wait flag", {voice_wait, op_active, store_en}, 3'h6);
    seen = 0;
    i_host.wr_nib(4'h2);
    i_host.wait_free();
    chk("stop in wait", {voice_wait, op_active}, 2'h0);
    chk("erase count", seen, 1);
    i_host.wr_nib(4'h1);
    voice_in <= 1'b1;
    i_host.wait_free();
    voice_in <= 1'b0;
    repeat (40) @(posedge sys_clk);
    chk("rec", {voice_wait, op_active, store_en}, 3'h3);
    i_host.wr_nib(4'h2);
    i_host.wait_free();
    chk("no erase", seen, 1);
    wr2(4'h7, 4'h0);
    i_host.wr_nib(4'h0);
    i_host.wr_nib(4'h1);
    i_host.wait_free();
    chk("phrase zero start", op_active, 1'b0);
    wr2(4'h7, 4'h0);
    i_host.wr_nib(4'h4);
    axi_rd(8'h0C);
    chk("bad flag", rd[3], 1'b1);
    axi_wr(8'h0C, 32'h8, 4'h0);
    axi_rd(8'h0C);
    chk("bad kept", rd[3], 1'b1);
    axi_wr(8'h0C, 32'h8, 4'h1);
    chk("write resp", rs, 2'h0);
    axi_rd(8'h0C);
    chk("bad cleared", rd[3], 1'b0);
    blk = 8'($urandom_range(255, 1));
    wr2(4'h5, 4'h1);
    wr2(4'h7, 4'h1);
    i_host.wr_nib(4'h0);
    wr2(4'hA, blk[3:0]);
    i_host.wr_nib(blk[7:4]);
    wr2(4'hA, 4'h0);
    i_host.wr_nib(4'h0);
    wr2(4'h5, 4'h2);
    wr2(4'hA, 4'h3);
    i_host.wr_nib(4'h0);
    axi_rd(8'h08);
    chk("blocks", rd, blk);
    wr2(4'h5, 4'h1);
    i_host.wr_nib(4'hB);
    i_host.rd_nib(q0);
    i_host.rd_nib(q1);
    chk("block read", {q1, q0}, blk);
    wr2(4'h5, 4'h3);
    i_host.wr_nib(4'h8);
    for (m = 0; m < 10; m++) begin
      nb = 4'($urandom);
      i_host.wr_nib(nb);
      ent[4 * m +: 4] = (m == 5 || m == 9) ? 4'h0 : nb;
      ent_q.push_back(ent[4 * m +: 4]);
    end
    i_host.wait_free();
    axi_rd(8'h10);
    chk("entry low", rd, ent[31:0]);
    axi_rd(8'h14);
    chk("entry high", rd, {24'h0, ent[39:32]});
    i_host.wr_nib(4'h9);
    for (m = 0; m < 10; m++) begin
      i_host.rd_nib(q0);
      chk("entry nibble", q0, ent_q.pop_front());
    end
    wr2(4'h7, 4'hF);
    i_host.wr_nib(4'h3);
    i_host.wr_nib(4'h4);
    i_host.wr_nib(4'h1);
    i_host.wait_free();
    chk("copy pulse", cps, 1);
    chk("playing", op_active, 1'b1);
    give_verdict();
  end
endmodule
